// *** common/tsic_defs.vh ***
// constants of the three-source interrupt controller
// Behaviour
// - The control register keeps the global enable in bit 0, the pin, timer and converter enables in bits 1 to 3 and their pending flags in bits 4 to 6, a one meaning enabled or pending.
// - Bit 7 of the control register does not exist and always reads zero.
// - With the global enable at zero no interrupt is serviced, whatever the source enables say.
// - A timer overflow, a finished conversion or an active pin edge sets the matching pending flag.
// - Servicing an enabled request pushes the program counter and loads the source's vector.
// - Entering any service clears the global enable, so nothing nests until software sets it again.
// - Requests arriving while the global enable is off still set and keep their flags for later.
// - While the return stack is full no request is acknowledged until the stack shrinks.
// - In normal operation the vector jump follows the request by 2 or 3 instruction cycles.
// - After a wake-up from sleep by a request the vector jump comes 3 or 4 instruction cycles later.
// - The interrupt return pops the saved program counter and resumes there.
// - Simultaneous requests are ordered pin first (04H), timer next (08H), converter last (0CH).
// - Servicing a source clears that source's pending flag.
// - The interrupt return also sets the global enable, the plain return leaves it alone.
// - Any pending flag going from low to high wakes the device, whatever the enables.
`ifndef TSIC_DEFS_VH
`define TSIC_DEFS_VH

// ***************************
// control register layout
// ***************************
`define TSIC_GIE_BIT       0
`define TSIC_EN_LSB        1
`define TSIC_EN_MSB        3
`define TSIC_FLAG_LSB      4
`define TSIC_FLAG_MSB      6
`define TSIC_CTRL_RESET    8'h00
`define TSIC_NSRC          3

// ***************************
// register bus map (word index)
// ***************************
`define TSIC_ADDR_W        2
`define TSIC_ADDR_CTRL     2'h0
`define TSIC_ADDR_STAT     2'h1
`define TSIC_DATA_ZERO     32'h00000000
`define TSIC_STAT_DEPTH_LSB 0
`define TSIC_STAT_DEPTH_MSB 2
`define TSIC_STAT_FULL_BIT 3
`define TSIC_STAT_BUSY_BIT 4
`define TSIC_STAT_SRC_LSB  5
`define TSIC_STAT_SRC_MSB  6

// ***************************
// program counter and stack
// ***************************
`define TSIC_PC_W          11
`define TSIC_PC_ZERO       11'h000
`define TSIC_VEC_PIN       11'h004
`define TSIC_VEC_TIMER     11'h008
`define TSIC_VEC_CONV      11'h00c
`define TSIC_STACK_DEPTH   4
`define TSIC_SP_W          3
`define TSIC_IDX_W         2
`define TSIC_SP_ZERO       3'h0
`define TSIC_SP_ONE        3'h1
`define TSIC_SP_FULL       3'h4

// ***************************
// sources and edge select
// ***************************
`define TSIC_SRC_PIN       2'h0
`define TSIC_SRC_TIMER     2'h1
`define TSIC_SRC_CONV      2'h2
`define TSIC_EDGE_OFF      2'h0
`define TSIC_EDGE_RISE     2'h1
`define TSIC_EDGE_FALL     2'h2
`define TSIC_EDGE_BOTH     2'h3

// ***************************
// instruction cycle timing
// ***************************
`define TSIC_DIV_ZERO      2'h0
`define TSIC_DIV_ONE       2'h1
`define TSIC_DIV_LAST      2'h3
`define TSIC_DELAY_RUN     2'h2
`define TSIC_DELAY_WAKE    2'h3
`define TSIC_CNT_ZERO      2'h0
`define TSIC_CNT_ONE       2'h1

`endif

// *** logic/tsic_prio.v ***
// fixed-priority selector for the three request sources
`timescale 1ns/1ps
`default_nettype none
`include "tsic_defs.vh"

module tsic_prio (
  input  wire [`TSIC_NSRC-1:0]  req,
  output reg                    anyReq,
  output reg  [1:0]             grantIdx
);

  // ***************************
  // selection
  // ***************************

  // pin beats timer beats converter
  always @* begin
    anyReq   = |req;
    grantIdx = `TSIC_SRC_PIN;
    if (req[`TSIC_SRC_PIN]) begin
      grantIdx = `TSIC_SRC_PIN;
    end else if (req[`TSIC_SRC_TIMER]) begin
      grantIdx = `TSIC_SRC_TIMER;
    end else if (req[`TSIC_SRC_CONV]) begin
      grantIdx = `TSIC_SRC_CONV;
    end
  end

endmodule // tsic_prio
`default_nettype wire

// *** logic/tsic_stack.v ***
// return address stack shared by calls and interrupt entries
`timescale 1ns/1ps
`default_nettype none
`include "tsic_defs.vh"

module tsic_stack (
  input  wire                   sys_clk,
  input  wire                   srst,
  input  wire                   push,
  input  wire                   pop,
  input  wire [`TSIC_PC_W-1:0]  pushData,
  output wire [`TSIC_PC_W-1:0]  topData,
  output wire                   full,
  output wire                   empty,
  output wire [`TSIC_SP_W-1:0]  depth
);

  reg  [`TSIC_PC_W-1:0]  mem [0:`TSIC_STACK_DEPTH-1];
  reg  [`TSIC_SP_W-1:0]  sp;
  wire [`TSIC_SP_W-1:0]  spDec;

  // ***************************
  // pointer and storage
  // ***************************

  assign spDec   = sp - `TSIC_SP_ONE;
  assign full    = (sp == `TSIC_SP_FULL);
  assign empty   = (sp == `TSIC_SP_ZERO);
  assign depth   = sp;
  assign topData = mem[spDec[`TSIC_IDX_W-1:0]];

  // push on full and pop on empty are dropped, the pointer never wraps
  always @(posedge sys_clk) begin
    if (srst) begin
      sp <= `TSIC_SP_ZERO;
    end else if (pop && !empty) begin
      sp <= spDec;
    end else if (push && !full) begin
      mem[sp[`TSIC_IDX_W-1:0]] <= pushData;
      sp <= sp + `TSIC_SP_ONE;
    end
  end

endmodule // tsic_stack
`default_nettype wire

// *** logic/tsic_top.v ***
// three-source interrupt controller with avalon register slave
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tsic_defs.vh"

module tsic_top (
  input  wire                     sys_clk,
  input  wire                     srst,
  // avalon-mm slave
  input  wire [`TSIC_ADDR_W-1:0]  avsAddress,
  input  wire                     avsRead,
  input  wire                     avsWrite,
  input  wire [31:0]              avsWritedata,
  input  wire [3:0]               avsByteenable,
  output reg  [31:0]              avsReaddata,
  output reg                      avsWaitrequest,
  // request sources
  input  wire                     pinIn,
  input  wire [1:0]               pinEdgeSel,
  input  wire                     timerOverflow,
  input  wire                     convDone,
  // program sequencer
  input  wire                     sleepMode,
  input  wire [`TSIC_PC_W-1:0]    pcCurrent,
  input  wire                     callExec,
  input  wire                     retExec,
  input  wire                     retiExec,
  output reg                      instrTick,
  output reg                      pcLoad,
  output reg  [`TSIC_PC_W-1:0]    pcLoadValue,
  output reg                      irqAck,
  output reg                      wakeUp
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_COUNT = 2'h1;

  reg  [1:0]              state;
  reg  [1:0]              next_state;
  reg  [1:0]              divCnt;
  reg  [1:0]              delayCnt;
  reg  [1:0]              next_delayCnt;
  reg  [1:0]              srcLatched;
  reg  [1:0]              next_srcLatched;
  reg                     pinPrev;
  reg                     globalIrqEnable;
  reg                     next_globalIrqEnable;
  reg  [`TSIC_NSRC-1:0]   srcEnable;
  reg  [`TSIC_NSRC-1:0]   srcFlag;
  reg  [`TSIC_NSRC-1:0]   next_srcFlag;
  reg  [`TSIC_NSRC-1:0]   flagClear;
  reg                     doJump;
  reg  [`TSIC_PC_W-1:0]   vector;
  reg                     pinEdge;
  wire [`TSIC_NSRC-1:0]   setEvent;
  wire [`TSIC_NSRC-1:0]   eligible;
  wire                    anyReq;
  wire [1:0]              grantIdx;
  wire [`TSIC_PC_W-1:0]   stackTop;
  wire                    stackFull;
  wire                    stackEmpty;
  wire [`TSIC_SP_W-1:0]   stackDepth;
  wire                    tickNow;
  wire                    busAccess;
  wire                    ctrlWrite;
  wire                    popNow;
  wire [7:0]              ctrlImage;
  wire [7:0]              ctrlReset;
  wire [7:0]              statImage;

  // ***************************
  // instruction cycle divider
  // ***************************

  // one instruction cycle is four system clocks
  always @(posedge sys_clk) begin
    if (srst) begin
      divCnt <= `TSIC_DIV_ZERO;
    end else begin
      divCnt <= divCnt + `TSIC_DIV_ONE;
    end
  end

  assign tickNow = (divCnt == `TSIC_DIV_LAST);

  // tick also goes out so the sequencer steps in lockstep
  always @(posedge sys_clk) begin
    if (srst) begin
      instrTick <= 1'b0;
    end else begin
      instrTick <= tickNow;
    end
  end

  // ***************************
  // request detection
  // ***************************

  // pin edge per the select code, code zero turns the pin off
  always @* begin
    case (pinEdgeSel)
      `TSIC_EDGE_OFF:  pinEdge = 1'b0;
      `TSIC_EDGE_RISE: pinEdge = pinIn && !pinPrev;
      `TSIC_EDGE_FALL: pinEdge = !pinIn && pinPrev;
      `TSIC_EDGE_BOTH: pinEdge = pinIn ^ pinPrev;
      default:         pinEdge = 1'b0;
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      pinPrev <= 1'b0;
    end else begin
      pinPrev <= pinIn;
    end
  end

  // flags set regardless of any enable, so they wait for later service
  assign setEvent[`TSIC_SRC_PIN]   = pinEdge;
  assign setEvent[`TSIC_SRC_TIMER] = timerOverflow;
  assign setEvent[`TSIC_SRC_CONV]  = convDone;

  // ***************************
  // arbitration
  // ***************************

  assign eligible = srcFlag & srcEnable;

  tsic_prio u_prio (
    .req      (eligible),
    .anyReq   (anyReq),
    .grantIdx (grantIdx)
  );

  // ***************************
  // return stack
  // ***************************

  assign popNow = retExec || retiExec;

  tsic_stack u_stack (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .push     (callExec || doJump),
    .pop      (popNow),
    .pushData (pcCurrent),
    .topData  (stackTop),
    .full     (stackFull),
    .empty    (stackEmpty),
    .depth    (stackDepth)
  );

  // ***************************
  // register bus decode
  // ***************************

  assign busAccess = (avsRead || avsWrite) && !avsWaitrequest;
  assign ctrlWrite = avsWrite && !avsWaitrequest && avsByteenable[0] &&
                     (avsAddress == `TSIC_ADDR_CTRL);

  // bit 7 is hard zero
  assign ctrlImage = {1'b0, srcFlag, srcEnable, globalIrqEnable};

  assign statImage = {1'b0, srcLatched, (state != ST_IDLE), stackFull, stackDepth};

  // one wait cycle, then one cycle of waitrequest low
  always @(posedge sys_clk) begin
    if (srst) begin
      avsWaitrequest <= 1'b1;
    end else begin
      avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
    end
  end

  // read data captured while waiting, stable at the completing edge
  always @(posedge sys_clk) begin
    if (srst) begin
      avsReaddata <= `TSIC_DATA_ZERO;
    end else if (avsRead && avsWaitrequest) begin
      case (avsAddress)
        `TSIC_ADDR_CTRL: avsReaddata <= {24'h000000, ctrlImage};
        `TSIC_ADDR_STAT: avsReaddata <= {24'h000000, statImage};
        default:         avsReaddata <= `TSIC_DATA_ZERO;
      endcase
    end else if (busAccess) begin
      avsReaddata <= avsReaddata;
    end
  end

  // ***************************
  // service sequencer
  // ***************************

  // decide at an instruction tick, count ticks, then jump
  always @* begin
    next_state      = state;
    next_delayCnt   = delayCnt;
    next_srcLatched = srcLatched;
    flagClear       = {`TSIC_NSRC{1'b0}};
    doJump          = 1'b0;
    case (state)
      ST_IDLE: begin
        // global enable gates all, a full stack holds off acknowledge
        if (tickNow && globalIrqEnable && anyReq && !stackFull) begin
          next_state      = ST_COUNT;
          next_srcLatched = grantIdx;
          flagClear[grantIdx] = 1'b1;
          if (sleepMode) begin
            next_delayCnt = `TSIC_DELAY_WAKE;
          end else begin
            next_delayCnt = `TSIC_DELAY_RUN;
          end
        end
      end
      ST_COUNT: begin
        if (tickNow) begin
          if (delayCnt == `TSIC_CNT_ONE) begin
            // a return in the same cycle owns the stack, retry next tick
            if (!popNow && !stackFull) begin
              doJump     = 1'b1;
              next_state = ST_IDLE;
              next_delayCnt = `TSIC_CNT_ZERO;
            end
          end else begin
            next_delayCnt = delayCnt - `TSIC_CNT_ONE;
          end
        end
      end
      default: begin
        next_state    = ST_IDLE;
        next_delayCnt = `TSIC_CNT_ZERO;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      state      <= ST_IDLE;
      delayCnt   <= `TSIC_CNT_ZERO;
      srcLatched <= `TSIC_SRC_PIN;
    end else begin
      state      <= next_state;
      delayCnt   <= next_delayCnt;
      srcLatched <= next_srcLatched;
    end
  end

  // ***************************
  // control register update
  // ***************************

  // software write first, then hardware clear, hardware set wins last
  always @* begin
    next_srcFlag = srcFlag;
    if (ctrlWrite) begin
      next_srcFlag = avsWritedata[`TSIC_FLAG_MSB:`TSIC_FLAG_LSB];
    end
    next_srcFlag = (next_srcFlag & ~flagClear) | setEvent;
  end

  // service entry clears, interrupt return sets, plain return leaves it
  always @* begin
    next_globalIrqEnable = globalIrqEnable;
    if (ctrlWrite) begin
      next_globalIrqEnable = avsWritedata[`TSIC_GIE_BIT];
    end
    if (|flagClear) begin
      next_globalIrqEnable = 1'b0;
    end
    if (retiExec && !stackEmpty) begin
      next_globalIrqEnable = 1'b1;
    end
  end

  // reset image sliced per field so every bit follows the one constant
  assign ctrlReset = `TSIC_CTRL_RESET;

  always @(posedge sys_clk) begin
    if (srst) begin
      globalIrqEnable <= ctrlReset[`TSIC_GIE_BIT];
      srcEnable       <= ctrlReset[`TSIC_EN_MSB:`TSIC_EN_LSB];
      srcFlag         <= ctrlReset[`TSIC_FLAG_MSB:`TSIC_FLAG_LSB];
    end else begin
      globalIrqEnable <= next_globalIrqEnable;
      srcFlag         <= next_srcFlag;
      if (ctrlWrite) begin
        srcEnable <= avsWritedata[`TSIC_EN_MSB:`TSIC_EN_LSB];
      end
    end
  end

  // ***************************
  // program counter outputs
  // ***************************

  always @* begin
    case (srcLatched)
      `TSIC_SRC_PIN:   vector = `TSIC_VEC_PIN;
      `TSIC_SRC_TIMER: vector = `TSIC_VEC_TIMER;
      `TSIC_SRC_CONV:  vector = `TSIC_VEC_CONV;
      default:         vector = `TSIC_VEC_PIN;
    endcase
  end

  // one-cycle load pulse, the value holds until the next load
  always @(posedge sys_clk) begin
    if (srst) begin
      pcLoad      <= 1'b0;
      pcLoadValue <= `TSIC_PC_ZERO;
      irqAck      <= 1'b0;
    end else begin
      pcLoad <= 1'b0;
      irqAck <= 1'b0;
      if (popNow && !stackEmpty) begin
        pcLoad      <= 1'b1;
        pcLoadValue <= stackTop;
      end else if (doJump) begin
        pcLoad      <= 1'b1;
        pcLoadValue <= vector;
        irqAck      <= 1'b1;
      end
    end
  end

  // ***************************
  // wake-up
  // ***************************

  // any rising flag wakes, enables play no part
  always @(posedge sys_clk) begin
    if (srst) begin
      wakeUp <= 1'b0;
    end else begin
      wakeUp <= |(next_srcFlag & ~srcFlag);
    end
  end

endmodule // tsic_top
`default_nettype wire

// *** verif/tsic_props.sv ***
// port checker for the three-source interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "tsic_defs.vh"

module tsic_props (
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire logic [`TSIC_ADDR_W-1:0] avsAddress,
  input wire logic                    avsRead,
  input wire logic                    avsWrite,
  input wire logic [31:0]             avsReaddata,
  input wire logic                    avsWaitrequest,
  input wire logic                    retExec,
  input wire logic                    retiExec,
  input wire logic                    instrTick,
  input wire logic                    pcLoad,
  input wire logic [`TSIC_PC_W-1:0]   pcLoadValue,
  input wire logic                    irqAck
);
  // ****************
  // port relations
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // bus answers one cycle after taking a request, for one cycle only
  bus_take_a: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("request not answered next cycle");
  wait_pulse_a: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low too long");
  bit_seven_a: assert property (!avsWaitrequest && avsRead && avsAddress == `TSIC_ADDR_CTRL
    |-> avsReaddata[31:7] == 25'h0)
    else $error("control read has upper bits set");
  // every jump goes to one of the three vectors
  vector_jump_a: assert property (irqAck |-> pcLoad && (pcLoadValue == `TSIC_VEC_PIN ||
    pcLoadValue == `TSIC_VEC_TIMER || pcLoadValue == `TSIC_VEC_CONV))
    else $error("ack without vector load");
  jump_on_tick_a: assert property (irqAck |-> instrTick)
    else $error("jump off the instruction cycle");
  tick_period_a: assert property (instrTick |=> !instrTick [*3] ##1 instrTick)
    else $error("instruction cycle not four clocks");
  // global enable drops at entry, so no second jump comes within eight cycles
  no_nest_a: assert property (irqAck |=> !irqAck [*8])
    else $error("second jump too soon");
  return_load_a: assert property (retExec || retiExec |=> pcLoad && !irqAck)
    else $error("return did not load the counter");
endmodule // tsic_props

bind tsic_top tsic_props u_props (
  .sys_clk       (sys_clk),
  .srst          (srst),
  .avsAddress    (avsAddress),
  .avsRead       (avsRead),
  .avsWrite      (avsWrite),
  .avsReaddata   (avsReaddata),
  .avsWaitrequest(avsWaitrequest),
  .retExec       (retExec),
  .retiExec      (retiExec),
  .instrTick     (instrTick),
  .pcLoad        (pcLoad),
  .pcLoadValue   (pcLoadValue),
  .irqAck        (irqAck)
);
`default_nettype wire

// *** verif/tsic_cpu_model.sv ***
// program sequencer model facing the controller
`timescale 1ns/1ps
`default_nettype none
`include "tsic_defs.vh"

module tsic_cpu_model #(
  parameter logic [`TSIC_PC_W-1:0] START_PC = 11'h100
) (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  instrTick,
  input  wire logic                  pcLoad,
  input  wire logic [`TSIC_PC_W-1:0] pcLoadValue,
  input  wire logic                  retiReq,
  output var  logic [`TSIC_PC_W-1:0] pcCurrent,
  output var  logic                  retiExec
);
  // counter steps per instruction; a load wins so a jump is never lost
  always @(posedge sys_clk) begin
    if (srst) begin
      pcCurrent <= START_PC;
      retiExec  <= 1'b0;
    end else begin
      retiExec <= retiReq;
      if (pcLoad)
        pcCurrent <= pcLoadValue;
      else if (instrTick)
        pcCurrent <= pcCurrent + 11'h001;
    end
  end
endmodule // tsic_cpu_model
`default_nettype wire

// *** verif/three_source_interrupt_controller_bench.sv ***
// testbench for the three-source interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "tsic_defs.vh"

module three_source_interrupt_controller_bench;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [1:0]  avsAddress = 2'h0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0]  avsByteenable = 4'h1;
  logic        pinIn = 1'b0;
  logic [1:0]  pinEdgeSel = `TSIC_EDGE_RISE;
  logic        timerOverflow = 1'b0;
  logic        convDone = 1'b0;
  logic        sleepMode = 1'b0;
  logic        callExec = 1'b0;
  logic        retExec = 1'b0;
  logic        retiReq = 1'b0;
  wire  [31:0] avsReaddata;
  wire         avsWaitrequest;
  wire         instrTick;
  wire         pcLoad;
  wire  [10:0] pcLoadValue;
  wire         irqAck;
  wire         wakeUp;
  wire  [10:0] pcCurrent;
  wire         retiExec;
  logic [31:0] rd;
  logic [10:0] retPc = 11'h0;
  int          errors = 0;
  int          n_tests = 0;
  int          acks = 0;
  int          wakes = 0;

  tsic_top u_dut (.sys_clk(sys_clk), .srst(srst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .pinIn(pinIn), .pinEdgeSel(pinEdgeSel),
    .timerOverflow(timerOverflow), .convDone(convDone), .sleepMode(sleepMode),
    .pcCurrent(pcCurrent), .callExec(callExec), .retExec(retExec),
    .retiExec(retiExec), .instrTick(instrTick), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .irqAck(irqAck), .wakeUp(wakeUp));
  tsic_cpu_model u_cpu (.sys_clk(sys_clk), .srst(srst), .instrTick(instrTick),
    .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .retiReq(retiReq),
    .pcCurrent(pcCurrent), .retiExec(retiExec));

  // ****************
  // clock, monitors, shared tasks
  // ****************
  initial forever #50 sys_clk = ~sys_clk;

  // counters let a scenario judge events it was not waiting on
  always @(posedge sys_clk) begin
    if (irqAck === 1'b1) acks <= acks + 1;
    if (wakeUp === 1'b1) wakes <= wakes + 1;
    if (pcLoad === 1'b1 && irqAck !== 1'b1) retPc <= pcLoadValue;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= d;
    avsByteenable <= be;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avsWaitrequest !== 1'b0 && k < 50);
    chk("waitrequest", 32'h0, {31'h0, avsWaitrequest});
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  // one-cycle strobes: pin, timer, conv, call, ret, reti
  task automatic kick(input logic [5:0] m);
    @(posedge sys_clk);
    {retiReq, retExec, callExec, convDone, timerOverflow, pinIn} <= m;
    @(posedge sys_clk);
    {retiReq, retExec, callExec, convDone, timerOverflow, pinIn} <= 6'h00;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic wait_ack(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (irqAck !== 1'b1 && n < 60);
    chk("irqAck", 32'h1, {31'h0, irqAck});
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b1, `TSIC_ADDR_CTRL, 32'hfe, 4'h1, rd);
    bus(1'b1, `TSIC_ADDR_CTRL, 32'h0, 4'h0, rd);
    bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
    chk("ctrl bits", 32'h7e, rd);
    bus(1'b1, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
    bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
    chk("flag clear", 32'h0, rd);
    bus(1'b0, 2'h3, 32'h0, 4'h1, rd);
    chk("unmapped", 32'h0, rd);
  endtask

  // every edge select code: pin raised and held, then lowered, global enable off
  task automatic t_edges;
    for (int c = 0; c < 4; c++) begin
      pinEdgeSel <= c[1:0];
      bus(1'b1, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
      pinIn <= 1'b1;
      bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
      chk("rise flag", {27'h0, c[0], 4'h0}, rd);
      bus(1'b1, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
      pinIn <= 1'b0;
      bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
      chk("fall flag", {27'h0, c[1], 4'h0}, rd);
    end
    pinEdgeSel <= `TSIC_EDGE_RISE;
  endtask

  // all three sources fire with the global enable off
  task automatic t_masked;
    int a0;
    int w0;
    bus(1'b1, `TSIC_ADDR_CTRL, 32'h0e, 4'h1, rd);
    a0 = acks;
    w0 = wakes;
    kick(6'h07);
    repeat (30) @(posedge sys_clk);
    chk("masked ack", a0, acks);
    chk("wake", 32'h1, {31'h0, wakes > w0});
    bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
    chk("held flags", 32'h7e, rd);
  endtask

  task automatic t_prio;
    int n;
    logic [10:0] pc;
    bus(1'b1, `TSIC_ADDR_CTRL, 32'h7f, 4'h1, rd);
    for (int i = 0; i < 3; i++) begin
      wait_ack(n);
      pc = pcCurrent;
      chk("vector", 4 * (i + 1), {21'h0, pcLoadValue});
      bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
      chk("entry", {24'h0, 8'h0e | (8'h70 & (8'h70 << (i + 1)))}, rd);
      kick(6'h20);
      chk("return pc", {21'h0, pc}, {21'h0, retPc});
    end
    bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
    chk("reti enable", 32'h0f, rd);
  endtask

  // jump latency awake and asleep, counted from the end of the pulse
  task automatic t_sleep;
    int n;
    for (int s = 0; s < 2; s++) begin
      sleepMode <= s[0];
      bus(1'b1, `TSIC_ADDR_CTRL, 32'h05, 4'h1, rd);
      @(posedge sys_clk);
      timerOverflow <= 1'b1;
      @(posedge sys_clk);
      timerOverflow <= 1'b0;
      wait_ack(n);
      chk("latency", 32'h1, {31'h0, n >= 9 + 4 * s && n <= 13 + 4 * s});
      kick(6'h20);
    end
    sleepMode <= 1'b0;
  endtask

  task automatic t_stack;
    int n;
    int a0;
    repeat (3) kick(6'h08);
    bus(1'b1, `TSIC_ADDR_CTRL, 32'h13, 4'h1, rd);
    wait_ack(n);
    bus(1'b1, `TSIC_ADDR_CTRL, 32'h25, 4'h1, rd);
    a0 = acks;
    repeat (30) @(posedge sys_clk);
    chk("full ack", a0, acks);
    bus(1'b0, `TSIC_ADDR_STAT, 32'h0, 4'h1, rd);
    chk("full status", 32'hc, {28'h0, rd[3:0]});
    kick(6'h10);
    wait_ack(n);
    chk("late vector", 32'h8, {21'h0, pcLoadValue});
    repeat (4) kick(6'h10);
    bus(1'b0, `TSIC_ADDR_CTRL, 32'h0, 4'h1, rd);
    chk("ret keeps", 32'h04, rd);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_edges();
    t_masked();
    t_prio();
    t_sleep();
    t_stack();
    print_verdict();
  end

  // the whole run needs a few hundred cycles
  initial begin
    #1000000;
    errors++;
    $display("BAD watchdog expected done seen hang");
    print_verdict();
  end
endmodule // three_source_interrupt_controller_bench
`default_nettype wire
